// *** hdl/sdp_cfg.svh ***
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH

// Register addresses on the byte write/read port
`define SDP_ADDR_HS_LO 8'h17
`define SDP_ADDR_PACK 8'h18
`define SDP_ADDR_FB0 8'h1A
`define SDP_ADDR_FB1 8'h1B
`define SDP_ADDR_FB2 8'h1C
`define SDP_ADDR_FB3 8'h1D
`define SDP_ADDR_FB4 8'h1E
`define SDP_ADDR_FB5 8'h1F
`define SDP_ADDR_STATUS 8'h20

// Packed byte field positions
`define SDP_PACK_LS_HI 6
`define SDP_PACK_LS_LO 4
`define SDP_PACK_HS_HI 2
`define SDP_PACK_HS_LO 0

// Divider limits
`define SDP_HS_MIN 11'h005
`define SDP_HS_MAX 11'h7FE
`define SDP_HS_ODD_MAX 11'h021
`define SDP_LS_EXP_MAX 3'h5
`define SDP_FB_MIN 43'h003C0000000
`define SDP_FB_MAX 43'h7FDFFFFFFFF

// Frequencies in Hz
`define SDP_FOSC_HZ 27'h347FF10
`define SDP_VCO_MIN_HZ 34'h283BAEC00
`define SDP_VCO_MAX_A_HZ 34'h2EC0B0E37
`define SDP_VCO_MAX_BC_HZ 34'h2D1CBCA59
`define SDP_FOUT_MIN_HZ 31'h00030D40
`define SDP_FOUT_MAX_A_HZ 31'h59682F00
`define SDP_FOUT_MAX_B_HZ 31'h2FAF0800
`define SDP_FOUT_MAX_C_HZ 31'h135F1B40

// Reset values of the divider settings
`define SDP_RST_HS 11'h046
`define SDP_RST_LS 3'h0
`define SDP_RST_FB 43'h0C7519CF2BF

`endif

// *** hdl/sdp_pkg.sv ***
package sdp_pkg;

  typedef enum logic [1:0] {
    SDP_IDLE,
    SDP_CALC,
    SDP_CHECK
  } sdp_state_e;

  typedef enum logic [1:0] {
    SDP_GRADE_A,
    SDP_GRADE_B,
    SDP_GRADE_C,
    SDP_GRADE_C_ALT
  } sdp_grade_e;

  typedef struct packed {
    logic [2:0] ls;
    logic [10:0] hs;
    logic [42:0] fb;
  } sdp_div_s;

  typedef struct packed {
    sdp_state_e st;
    sdp_div_s pend;
    sdp_div_s act;
    logic [69:0] vco;
    logic [15:0] tot;
    logic valid;
    logic err;
    logic done;
    logic [7:0] rdata;
    logic [1:0] grade_meta;
    sdp_grade_e grade;
  } sdp_top_state_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic phase;
  } sdp_div_state_s;

  // Codes above five still divide by thirty-two
  function automatic logic [2:0] sdp_ls_exp(input logic [2:0] code);
    sdp_ls_exp = (code > 3'h5) ? 3'h5 : code;
  endfunction : sdp_ls_exp

  // Total output divide, high-speed ratio times power-of-two ratio
  function automatic logic [15:0] sdp_total(input logic [10:0] hs, input logic [2:0] code);
    sdp_total = 16'({5'h00, hs} << sdp_ls_exp(code));
  endfunction : sdp_total

endpackage : sdp_pkg

// *** hdl/sdp_outdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdp_cfg.svh"

module sdp_outdiv (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Active divider settings
  input wire logic [10:0] hs_i,
  input wire logic [2:0] ls_i,
  // Divided clock
  output logic div_clk_o
);
  import sdp_pkg::*;

  sdp_div_state_s s_reg;
  sdp_div_state_s s_next;
  logic late_reg;
  logic [15:0] total;
  logic odd_mode;

  always_comb begin
    total = sdp_total(hs_i, ls_i);
    // Odd totals only occur with the power-of-two stage bypassed
    odd_mode = (sdp_ls_exp(ls_i) == 3'h0) && hs_i[0];
    s_next = s_reg;
    if (s_reg.cnt >= total - 16'h0001) begin
      s_next.cnt = 16'h0000;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
    s_next.phase = (s_next.cnt < ((total + 16'h0001) >> 1));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Half-cycle late copy trims the extra half period of odd ratios
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      late_reg <= 1'b0;
    end else begin
      late_reg <= s_reg.phase;
    end
  end

  assign div_clk_o = odd_mode ? (s_reg.phase & late_reg) : s_reg.phase;

endmodule : sdp_outdiv

`default_nettype wire

// *** hdl/sdp_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sdp_cfg.svh"

// Function
// - High-speed ratio must lie between 5 and 2046 inclusive.
// - Low-speed code n divides by 2^n; codes 6 and 7 divide by 32.
// - With low-speed code 0, odd high-speed ratios only from 5 to 33.
// - With low-speed code 1 or more, any ratio 5 to 2046 is valid.
// - Odd low ratios still give 50% duty via duty correction.
// - Feedback divider is 11.32 unsigned, valid 03C0000000 to 7FDFFFFFFFF.
// - Output frequency is VCO frequency over high-speed times low-speed ratio.
// - VCO frequency is 55.05 MHz reference times feedback divider.
// - VCO from 10.8 GHz to 12.550082103 (grade A) or 12.109728345 GHz.
// - Output 0.2 MHz up to 1500, 800 or 325 MHz per grade.
// - All three divider values are unsigned, never negative.
// - Shared byte: low-speed code in bits 6:4, ratio bits 10:8 in 2:0.
module sdp_top (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // Speed grade strap
  input wire logic [1:0] GRADE_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // Status
  output logic CFG_VALID_O,
  output logic CFG_ERROR_O,
  output logic CFG_DONE_O,
  output sdp_pkg::sdp_div_s ACTIVE_DIV_O,
  // Synthesised clock
  output logic CLK_OUT_O
);
  import sdp_pkg::*;

  sdp_top_state_s s_reg;
  sdp_top_state_s s_next;
  logic hs_ok;
  logic fb_ok;
  logic vco_ok;
  logic fout_ok;
  logic [33:0] vco_max;
  logic [30:0] fout_max;
  logic [79:0] fout_hi;
  logic [79:0] fout_lo;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.grade_meta = GRADE_I;
    s_next.grade = sdp_grade_e'(s_reg.grade_meta);

    // Byte writes land in the pending set; range is checked later
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        `SDP_ADDR_HS_LO: s_next.pend.hs[7:0] = REG_WDATA_I;
        `SDP_ADDR_PACK: begin
          s_next.pend.ls = REG_WDATA_I[`SDP_PACK_LS_HI:`SDP_PACK_LS_LO];
          s_next.pend.hs[10:8] = REG_WDATA_I[`SDP_PACK_HS_HI:`SDP_PACK_HS_LO];
        end
        `SDP_ADDR_FB0: s_next.pend.fb[7:0] = REG_WDATA_I;
        `SDP_ADDR_FB1: s_next.pend.fb[15:8] = REG_WDATA_I;
        `SDP_ADDR_FB2: s_next.pend.fb[23:16] = REG_WDATA_I;
        `SDP_ADDR_FB3: s_next.pend.fb[31:24] = REG_WDATA_I;
        `SDP_ADDR_FB4: s_next.pend.fb[39:32] = REG_WDATA_I;
        `SDP_ADDR_FB5: s_next.pend.fb[42:40] = REG_WDATA_I[2:0];
        default: ;
      endcase
    end

    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `SDP_ADDR_HS_LO: s_next.rdata = s_reg.pend.hs[7:0];
        `SDP_ADDR_PACK: s_next.rdata = {1'b0, s_reg.pend.ls, 1'b0, s_reg.pend.hs[10:8]};
        `SDP_ADDR_FB0: s_next.rdata = s_reg.pend.fb[7:0];
        `SDP_ADDR_FB1: s_next.rdata = s_reg.pend.fb[15:8];
        `SDP_ADDR_FB2: s_next.rdata = s_reg.pend.fb[23:16];
        `SDP_ADDR_FB3: s_next.rdata = s_reg.pend.fb[31:24];
        `SDP_ADDR_FB4: s_next.rdata = s_reg.pend.fb[39:32];
        `SDP_ADDR_FB5: s_next.rdata = {5'h00, s_reg.pend.fb[42:40]};
        `SDP_ADDR_STATUS: s_next.rdata = {5'h00, s_reg.valid, s_reg.err, s_reg.st != SDP_IDLE};
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Ratio limits; odd ratios above 33 need the power-of-two stage
    hs_ok = (s_reg.pend.hs >= `SDP_HS_MIN) && (s_reg.pend.hs <= `SDP_HS_MAX);
    if (sdp_ls_exp(s_reg.pend.ls) == 3'h0 && s_reg.pend.hs[0]) begin
      hs_ok = hs_ok && (s_reg.pend.hs <= `SDP_HS_ODD_MAX);
    end // Nonzero code keeps full span
    fb_ok = (s_reg.pend.fb >= `SDP_FB_MIN) && (s_reg.pend.fb <= `SDP_FB_MAX);

    // Comparisons carry a 2^32 scale from the fraction bits
    vco_max = (s_reg.grade == SDP_GRADE_A) ? `SDP_VCO_MAX_A_HZ : `SDP_VCO_MAX_BC_HZ;
    vco_ok = ({s_reg.vco} >= {4'h0, `SDP_VCO_MIN_HZ, 32'h0}) &&
             ({s_reg.vco} <= {4'h0, vco_max, 32'h0});
    case (s_reg.grade)
      SDP_GRADE_A: fout_max = `SDP_FOUT_MAX_A_HZ;
      SDP_GRADE_B: fout_max = `SDP_FOUT_MAX_B_HZ;
      default: fout_max = `SDP_FOUT_MAX_C_HZ;
    endcase
    // Output within span iff fmin*div <= vco <= fmax*div
    fout_hi = {1'b0, 48'({17'h0, fout_max} * {32'h0, s_reg.tot}), 31'h0} << 1;
    fout_lo = {1'b0, 48'({17'h0, `SDP_FOUT_MIN_HZ} * {32'h0, s_reg.tot}), 31'h0} << 1;
    fout_ok = ({10'h0, s_reg.vco} <= fout_hi) && ({10'h0, s_reg.vco} >= fout_lo);

    case (s_reg.st)
      SDP_IDLE: begin
        if (REG_WR_I && REG_ADDR_I == `SDP_ADDR_FB5) begin
          s_next.st = SDP_CALC;
        end
      end
      SDP_CALC: begin
        s_next.vco = 70'({27'h0, s_reg.pend.fb} * {43'h0, `SDP_FOSC_HZ});
        s_next.tot = sdp_total(s_reg.pend.hs, s_reg.pend.ls);
        s_next.st = SDP_CHECK;
      end
      SDP_CHECK: begin
        // Only a fully legal set reaches the output divider
        if (hs_ok && fb_ok && vco_ok && fout_ok) begin
          s_next.act = s_reg.pend;
          s_next.valid = 1'b1;
          s_next.err = 1'b0;
        end else begin
          s_next.valid = 1'b0;
          s_next.err = 1'b1;
        end
        s_next.done = 1'b1;
        s_next.st = SDP_IDLE;
      end
      default: s_next.st = SDP_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s_reg <= '0;
      s_reg.pend <= '{ls: `SDP_RST_LS, hs: `SDP_RST_HS, fb: `SDP_RST_FB};
      s_reg.act <= '{ls: `SDP_RST_LS, hs: `SDP_RST_HS, fb: `SDP_RST_FB};
      s_reg.valid <= 1'b1;
      s_reg.grade <= SDP_GRADE_C;
    end else begin
      s_reg <= s_next;
    end
  end

  // Reference clock stands in for the VCO; ratios still hold
  sdp_outdiv u_outdiv (
    .clk_i(REF_CLK_I),
    .rst_i(RESET_I),
    .hs_i(s_reg.act.hs),
    .ls_i(s_reg.act.ls),
    .div_clk_o(CLK_OUT_O)
  );

  assign REG_RDATA_O = s_reg.rdata;
  assign CFG_VALID_O = s_reg.valid;
  assign CFG_ERROR_O = s_reg.err;
  assign CFG_DONE_O = s_reg.done;
  assign ACTIVE_DIV_O = s_reg.act;

endmodule : sdp_top

`default_nettype wire

// *** sim/sdp_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdp_top_properties (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_RDATA_O,
  // Status
  input wire logic CFG_VALID_O,
  input wire logic CFG_ERROR_O,
  input wire logic CFG_DONE_O,
  input wire sdp_pkg::sdp_div_s ACTIVE_DIV_O
);
  import sdp_pkg::*;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  done_pulse_a: assert property (CFG_DONE_O |=> !CFG_DONE_O)
    else $error("done too long");
  done_delay_a: assert property (REG_WR_I && REG_ADDR_I == 8'h1F |-> ##[1:3] CFG_DONE_O)
    else $error("done late");
  status_pair_a: assert property (CFG_VALID_O != CFG_ERROR_O)
    else $error("status clash");
  fail_hold_a: assert property (CFG_DONE_O && CFG_ERROR_O |-> $stable(ACTIVE_DIV_O))
    else $error("moved on error");
  active_move_a: assert property ($changed(ACTIVE_DIV_O) |-> CFG_DONE_O && CFG_VALID_O)
    else $error("moved unasked");
  hs_span_a: assert property (CFG_VALID_O |-> ACTIVE_DIV_O.hs inside {[11'h005:11'h7FE]})
    else $error("ratio span");
  hs_parity_a: assert property (CFG_VALID_O && ACTIVE_DIV_O.ls == 3'h0
    && ACTIVE_DIV_O.hs > 11'h021 |-> !ACTIVE_DIV_O.hs[0]) else $error("odd ratio");
  fb_span_a: assert property (CFG_VALID_O
    |-> ACTIVE_DIV_O.fb inside {[43'h003C0000000:43'h7FDFFFFFFFF]}) else $error("fb span");
  pack_gaps_a: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 8'h18
    |-> REG_RDATA_O[7] == 1'b0 && REG_RDATA_O[3] == 1'b0) else $error("unused bits");
endmodule : sdp_top_properties

bind sdp_top sdp_top_properties u_props (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_RDATA_O(REG_RDATA_O), .CFG_VALID_O(CFG_VALID_O), .CFG_ERROR_O(CFG_ERROR_O),
  .CFG_DONE_O(CFG_DONE_O), .ACTIVE_DIV_O(ACTIVE_DIV_O));
`default_nettype wire

// *** sim/sdp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdp_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // Register port
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  import sdp_pkg::*;
  initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
  // Strobe stays up so bytes can go back to back
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) #1 {wr_o, addr_o, wdata_o} = {1'b1, a, d};
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i) #1 {wr_o, rd_o, addr_o} = {2'b01, a};
    @(posedge clk_i) #1 {rd_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
  endtask : get
  // Top feedback byte last, since it starts the check
  task automatic send_set(input sdp_div_s s);
    put(8'h17, s.hs[7:0]);
    put(8'h18, {1'b0, s.ls, 1'b0, s.hs[10:8]});
    for (int i = 0; i < 6; i++) begin
      put(8'(8'h1A + i), 8'(s.fb >> (8 * i)));
    end
    @(posedge clk_i) #1 {wr_o, addr_o, wdata_o} = {1'b0, ~addr_o, ~wdata_o};
  endtask : send_set
endmodule : sdp_host_model
`default_nettype wire

// *** sim/sdp_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdp_top_tb;
  import sdp_pkg::*;
  typedef struct packed {
    logic [1:0] g;
    sdp_div_s d;
    logic v;
  } sdp_row_s;
  // Planned set for 156.75 MHz: min total, code 0, ratio 70, then fb
  localparam logic [42:0] F = 43'h0C7519CF2BF;
  localparam sdp_div_s RST_DIV = {3'h0, 11'h046, F};
  // Grade, divider set, should it pass
  sdp_row_s rows [20] = '{
    {2'h2, 3'h0, 11'h046, F, 1'b1}, {2'h2, 3'h0, 11'h045, F, 1'b0},
    {2'h2, 3'h1, 11'h045, F, 1'b1}, {2'h2, 3'h5, 11'h004, F, 1'b0},
    {2'h2, 3'h1, 11'h7FF, F, 1'b0}, {2'h2, 3'h3, 11'h7FE, F, 1'b1},
    {2'h1, 3'h0, 11'h021, F, 1'b1}, {2'h2, 3'h0, 11'h021, F, 1'b0},
    {2'h3, 3'h0, 11'h021, F, 1'b0}, {2'h2, 3'h7, 11'h3E8, F, 1'b1},
    {2'h2, 3'h6, 11'h3E8, F, 1'b1}, {2'h2, 3'h2, 11'h046, F, 1'b1},
    {2'h2, 3'h4, 11'h046, F, 1'b1}, {2'h2, 3'h5, 11'h7FE, F, 1'b0},
    {2'h2, 3'h0, 11'h046, 43'h0C300000000, 1'b0},
    {2'h0, 3'h0, 11'h014, 43'h0E400000000, 1'b0},
    {2'h1, 3'h0, 11'h014, 43'h0E300000000, 1'b0},
    {2'h0, 3'h0, 11'h014, 43'h0E300000000, 1'b1},
    {2'h0, 3'h0, 11'h007, F, 1'b0}, {2'h0, 3'h0, 11'h009, F, 1'b1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] grade = 2'h2;
  logic wr, rd, valid, err, done, clk_out, prev;
  logic [7:0] addr, wdata, rdata, rd_val;
  sdp_div_s act, exp_div;
  int fail_count = 0;
  int num_checks = 0;
  int n, highs;
  sdp_top u_dut (.REF_CLK_I(clk), .RESET_I(rst), .GRADE_I(grade), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .CFG_VALID_O(valid), .CFG_ERROR_O(err), .CFG_DONE_O(done), .ACTIVE_DIV_O(act),
    .CLK_OUT_O(clk_out));
  sdp_host_model u_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [56:0] e, input logic [56:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // Check needs three edges, twenty is ample
  task automatic wait_done();
    for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk) #1;
    chk("done", 57'(1'b1), 57'(done));
    if (done !== 1'b1) give_verdict();
  endtask : wait_done
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    exp_div = RST_DIV;
    chk("reset active", RST_DIV, act);
    chk("reset status", 57'(3'b100), 57'({valid, err, done}));
    foreach (rows[i]) begin
      grade = rows[i].g;
      u_host.send_set(rows[i].d);
      wait_done();
      if (rows[i].v) exp_div = rows[i].d;
      chk("valid", 57'(rows[i].v), 57'(valid));
      chk("error", 57'(!rows[i].v), 57'(err));
      chk("active", exp_div, act);
      $display("row %0d done", i);
    end
    // New ratio applies at once; a count past it wraps on the next edge
    repeat (30) @(posedge clk);
    #1 prev = clk_out;
    for (n = 0; n < 100 && !(clk_out === 1'b1 && prev === 1'b0); n++) begin
      prev = clk_out;
      #2;
    end
    chk("clock edge", 57'(1'b1), 57'(clk_out === 1'b1 && prev === 1'b0));
    highs = 0;
    repeat (72) begin
      highs += int'(clk_out === 1'b1);
      #2;
    end
    chk("clock high samples", 57'(36), 57'(highs));
    $display("clock test done");
    u_host.get(8'h17, rd_val);
    chk("ratio low byte", 57'(8'h09), 57'(rd_val));
    u_host.put(8'h18, 8'hFF);
    u_host.get(8'h18, rd_val);
    chk("packed byte", 57'(8'h77), 57'(rd_val));
    u_host.get(8'h55, rd_val);
    chk("unmapped", 57'(8'h00), 57'(rd_val));
    $display("register test done");
    @(posedge clk) #1 rst = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    chk("mid reset active", RST_DIV, act);
    chk("mid reset status", 57'(3'b100), 57'({valid, err, done}));
    $display("reset test done");
    give_verdict();
  end
endmodule : sdp_top_tb
`default_nettype wire
